// File: bic_pkg.sv
/*
  Package for the branch and interrupt event counter: event codes, unit masks,
  widths and reset values shared by the counter and its event decoder.
  Assumes a single core clock and a synchronous active-low reset.
*/
package bic_pkg;
  localparam int BIC_SEL_W = 8;
  localparam int BIC_CNT_W = 48;
  localparam logic [7:0] BIC_EVT_BR_ANY = 8'hc4;
  localparam logic [7:0] BIC_MSK_BR_ANY = 8'h0f;
  localparam logic [7:0] BIC_EVT_BR_MISP = 8'hc5;
  localparam logic [7:0] BIC_MSK_BR_MISP = 8'h00;
  localparam logic [7:0] BIC_EVT_INT = 8'hc6;
  localparam logic [7:0] BIC_MSK_INT_DIS = 8'h01;
  localparam logic [7:0] BIC_MSK_INT_PEND = 8'h02;
  localparam logic [47:0] BIC_CNT_RST = 48'h0;
  localparam logic [31:0] BIC_TAG_RST = 32'h0;

  typedef enum logic [2:0] {
    bic_sel_none,
    bic_sel_br_alt,
    bic_sel_br_misp,
    bic_sel_int_dis,
    bic_sel_int_pend
  } bic_sel_t;

  // Selector decode, shared by the decoder and the assertions
  function automatic bic_sel_t bic_decode(input logic [7:0] evt, input logic [7:0] msk);
    if (evt == BIC_EVT_BR_ANY && msk == BIC_MSK_BR_ANY) begin
      return bic_sel_br_alt;
    end else if (evt == BIC_EVT_BR_MISP && msk == BIC_MSK_BR_MISP) begin
      return bic_sel_br_misp;
    end else if (evt == BIC_EVT_INT && msk == BIC_MSK_INT_DIS) begin
      return bic_sel_int_dis;
    end else if (evt == BIC_EVT_INT && msk == BIC_MSK_INT_PEND) begin
      return bic_sel_int_pend;
    end
    return bic_sel_none;
  endfunction : bic_decode
endpackage : bic_pkg

// File: bic_evt_if.sv
/*
  Interface carrying the decoded selection and the per-cycle event pulse
  from the event decoder to the counter. Assumes one clock domain.
*/
`timescale 1ns/10ps
interface bic_evt_if;
  import bic_pkg::*;
  bic_sel_t sel;
  logic hit;
  logic [31:0] hit_tag;
  modport src (output sel, output hit, output hit_tag);
  modport dst (input sel, input hit, input hit_tag);
endinterface : bic_evt_if

// File: bic_evt_decode.sv
/*
  Event decoder: turns the selector and the core status lines into one
  count pulse per cycle, with the tag of the causing branch.
  Assumes retire and interrupt status are synchronous to clk_in.
*/
`timescale 1ns/10ps
module bic_evt_decode
  import bic_pkg::*;
(
  // Selector
  input wire logic [BIC_SEL_W-1:0] evt_sel_in,
  input wire logic [BIC_SEL_W-1:0] umask_in,
  // Retire and interrupt status
  input wire logic br_retire_in,
  input wire logic br_pred_taken_in,
  input wire logic br_taken_in,
  input wire logic [31:0] br_tag_in,
  input wire logic int_disabled_in,
  input wire logic int_pending_in,
  // Decoded event
  bic_evt_if.src evt
);
  logic misp;

  // Mispredict is a direction mismatch, either way round
  assign misp = br_retire_in && (br_pred_taken_in != br_taken_in);
  assign evt.sel = bic_decode(evt_sel_in, umask_in);
  assign evt.hit_tag = br_tag_in;

  always_comb begin
    case (evt.sel)
      bic_sel_br_alt: evt.hit = misp;
      bic_sel_br_misp: evt.hit = misp;
      bic_sel_int_dis: evt.hit = int_disabled_in;
      bic_sel_int_pend: evt.hit = int_disabled_in && int_pending_in;
      default: evt.hit = 1'b0;
    endcase
  end
endmodule : bic_evt_decode

// File: bic_counter.sv
/*
  Branch and interrupt event counter: selects one event by event number and
  unit mask and counts it on the core clock, recording the tag of the last
  counted branch for the precise event.
  Assumes the selector is written by software elsewhere and held stable.
*/
`timescale 1ns/10ps
// Functional notes
// - Event c4h with mask 0fh counts each retired mispredicted branch, same as the dedicated event.
// - Event c5h counts one for every retired branch that was mispredicted.
// - Event c5h is precise: each count records the tag of the exact branch that caused it.
// - A branch is mispredicted when its predicted direction differs from its resolved direction.
// - Event c6h with mask 01h counts every cycle with interrupt acceptance disabled.
// - Event c6h with mask 02h counts every cycle with an interrupt pending while disabled.
module bic_counter
  import bic_pkg::*;
#(
  parameter int CNT_W = BIC_CNT_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Selector
  input wire logic [BIC_SEL_W-1:0] evt_sel_in,
  input wire logic [BIC_SEL_W-1:0] umask_in,
  // Retire and interrupt status
  input wire logic br_retire_in,
  input wire logic br_pred_taken_in,
  input wire logic br_taken_in,
  input wire logic [31:0] br_tag_in,
  input wire logic int_disabled_in,
  input wire logic int_pending_in,
  // Count and precise record
  output logic [CNT_W-1:0] count_out,
  output logic precise_valid_out,
  output logic [31:0] precise_tag_out
);
  bic_evt_if evt ();
  logic [CNT_W-1:0] next_count;

  bic_evt_decode u_decode (
    .evt_sel_in(evt_sel_in),
    .umask_in(umask_in),
    .br_retire_in(br_retire_in),
    .br_pred_taken_in(br_pred_taken_in),
    .br_taken_in(br_taken_in),
    .br_tag_in(br_tag_in),
    .int_disabled_in(int_disabled_in),
    .int_pending_in(int_pending_in),
    .evt(evt)
  );

  // Wraps silently; overflow handling lives outside this block
  assign next_count = evt.hit ? count_out + CNT_W'(1) : count_out;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      count_out <= CNT_W'(BIC_CNT_RST);
    end else begin
      count_out <= next_count;
    end
  end

  // Tag captured the same cycle as the count, so skid never misattributes
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      precise_valid_out <= 1'b0;
      precise_tag_out <= BIC_TAG_RST;
    end else begin
      precise_valid_out <= evt.hit && evt.sel == bic_sel_br_misp;
      if (evt.hit && evt.sel == bic_sel_br_misp) begin
        precise_tag_out <= evt.hit_tag;
      end
    end
  end

  logic misp_c;
  assign misp_c = br_retire_in && (br_pred_taken_in != br_taken_in);

  property p_alt_branch;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_alt) |=>
        count_out == $past(count_out) + CNT_W'($past(misp_c));
  endproperty
  a_alt_branch: assert property (p_alt_branch) else $error("alt branch count wrong");

  property p_misp_branch;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c) |=> count_out == $past(count_out) + CNT_W'(1);
  endproperty
  a_misp_branch: assert property (p_misp_branch) else $error("mispredict not counted");

  property p_precise;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c) |=>
        precise_valid_out && precise_tag_out == $past(br_tag_in);
  endproperty
  a_precise: assert property (p_precise) else $error("precise tag wrong");

  property p_correct_pred;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && br_retire_in && br_pred_taken_in == br_taken_in) |=>
        $stable(count_out);
  endproperty
  a_correct_pred: assert property (p_correct_pred) else $error("correct branch counted");

  property p_int_dis;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_dis) |=>
        count_out == $past(count_out) + CNT_W'($past(int_disabled_in));
  endproperty
  a_int_dis: assert property (p_int_dis) else $error("disabled cycles wrong");

  property p_int_pend;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_pend) |=>
        count_out == $past(count_out) + CNT_W'($past(int_disabled_in && int_pending_in));
  endproperty
  a_int_pend: assert property (p_int_pend) else $error("pending cycles wrong");

  property p_no_sel;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_none) [*2] |=> $stable(count_out);
  endproperty
  a_no_sel: assert property (p_no_sel) else $error("count moved without selection");

  property p_run_dis;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_dis && int_disabled_in) [*3] |=>
        count_out == $past(count_out, 3) + CNT_W'(3);
  endproperty
  a_run_dis: assert property (p_run_dis) else $error("disabled run miscounted");

  property p_misp_quiet;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && !misp_c) |=> $stable(count_out);
  endproperty
  a_misp_quiet: assert property (p_misp_quiet) else $error("c5h counted without a mispredict");

  property p_misp_run;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c) [*3] |=>
        count_out == $past(count_out, 3) + CNT_W'(3);
  endproperty
  a_misp_run: assert property (p_misp_run) else $error("back-to-back mispredicts miscounted");

  property p_misp_nt;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && br_retire_in && !br_pred_taken_in && br_taken_in) |=>
        count_out == $past(count_out) + CNT_W'(1);
  endproperty
  a_misp_nt: assert property (p_misp_nt) else $error("not-taken prediction miss lost");

  // Only a counted c5h branch may pulse or move the record, so c4h never looks precise
  property p_precise_quiet;
    @(posedge clk_in) disable iff (!rst_b_in)
      !(bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c) |=>
        !precise_valid_out && $stable(precise_tag_out);
  endproperty
  a_precise_quiet: assert property (p_precise_quiet) else $error("stray precise record");

  property p_alt_correct;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_br_alt && br_retire_in && br_pred_taken_in == br_taken_in) |=>
        $stable(count_out);
  endproperty
  a_alt_correct: assert property (p_alt_correct) else $error("correct c4h branch counted");

  property p_int_idle;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_dis && !int_disabled_in) |=> $stable(count_out);
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("enabled cycle counted");

  property p_pend_idle;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_pend && !(int_disabled_in && int_pending_in)) |=>
        $stable(count_out);
  endproperty
  a_pend_idle: assert property (p_pend_idle) else $error("cycle without pending and disabled counted");

  property p_pend_run;
    @(posedge clk_in) disable iff (!rst_b_in)
      (bic_decode(evt_sel_in, umask_in) == bic_sel_int_pend && int_disabled_in && int_pending_in) [*3] |=>
        count_out == $past(count_out, 3) + CNT_W'(3);
  endproperty
  a_pend_run: assert property (p_pend_run) else $error("pending run miscounted");

  // Reference decode kept apart from the shared function on purpose, so a slip there shows up here
  logic [CNT_W-1:0] ref_count;
  logic ref_hit;

  always_comb begin
    ref_hit = 1'b0;
    if (evt_sel_in == BIC_EVT_BR_ANY && umask_in == BIC_MSK_BR_ANY) begin
      ref_hit = misp_c;
    end else if (evt_sel_in == BIC_EVT_BR_MISP && umask_in == BIC_MSK_BR_MISP) begin
      ref_hit = misp_c;
    end else if (evt_sel_in == BIC_EVT_INT && umask_in == BIC_MSK_INT_DIS) begin
      ref_hit = int_disabled_in;
    end else if (evt_sel_in == BIC_EVT_INT && umask_in == BIC_MSK_INT_PEND) begin
      ref_hit = int_disabled_in && int_pending_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ref_count <= CNT_W'(BIC_CNT_RST);
    end else if (ref_hit) begin
      ref_count <= ref_count + CNT_W'(1);
    end
  end

  property p_ref_count;
    @(posedge clk_in) disable iff (!rst_b_in)
      count_out == ref_count;
  endproperty
  a_ref_count: assert property (p_ref_count) else $error("count differs from reference");

  c_misp: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c);
  c_dis: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    bic_decode(evt_sel_in, umask_in) == bic_sel_int_dis && int_disabled_in);
  c_misp_run: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    (bic_decode(evt_sel_in, umask_in) == bic_sel_br_misp && misp_c) [*3]);
  c_alt: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    bic_decode(evt_sel_in, umask_in) == bic_sel_br_alt && misp_c);
  c_pend: cover property (@(posedge clk_in) disable iff (!rst_b_in)
    bic_decode(evt_sel_in, umask_in) == bic_sel_int_pend && int_disabled_in && int_pending_in);
endmodule : bic_counter

// File: bic_counter_tb.sv
/*
  Self-checking bench for the branch and interrupt event counter.
  Assumes bic_pkg is compiled first; the design's own assertions ride along.
*/
`timescale 1ns/10ps
module bic_counter_tb;
  import bic_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] evt_sel_in = 8'h00;
  logic [7:0] umask_in = 8'h00;
  logic br_retire_in = 1'b0;
  logic br_pred_taken_in = 1'b0;
  logic br_taken_in = 1'b0;
  logic [31:0] br_tag_in = 32'h0;
  logic int_disabled_in = 1'b0;
  logic int_pending_in = 1'b0;
  logic [47:0] count_out;
  logic precise_valid_out;
  logic [31:0] precise_tag_out;
  int failures = 0;
  int comparisons = 0;
  always #5 clk_in = ~clk_in;
  bic_counter u_bic_counter (.clk_in(clk_in), .rst_b_in(rst_b_in), .evt_sel_in(evt_sel_in),
    .umask_in(umask_in), .br_retire_in(br_retire_in), .br_pred_taken_in(br_pred_taken_in),
    .br_taken_in(br_taken_in), .br_tag_in(br_tag_in), .int_disabled_in(int_disabled_in),
    .int_pending_in(int_pending_in), .count_out(count_out), .precise_valid_out(precise_valid_out),
    .precise_tag_out(precise_tag_out));
  task close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Holds one input set for n sampling edges, idles, then checks the count step
  task run(input logic [7:0] sel, input logic [7:0] msk, input logic ret, input logic pt, input logic tk,
           input logic [31:0] tag, input logic dis, input logic pend, input int n, input int delta);
    logic [47:0] base;
    base = count_out;
    @(posedge clk_in);
    evt_sel_in <= sel;
    umask_in <= msk;
    br_retire_in <= ret;
    br_pred_taken_in <= pt;
    br_taken_in <= tk;
    br_tag_in <= tag;
    int_disabled_in <= dis;
    int_pending_in <= pend;
    repeat (n) @(posedge clk_in);
    br_retire_in <= 1'b0;
    int_disabled_in <= 1'b0;
    int_pending_in <= 1'b0;
    #1;
    chk(count_out, base + 48'(delta), "count step");
  endtask : run
  task t_reset;
    chk(count_out, 48'h0, "reset count");
    chk({47'h0, precise_valid_out}, 48'h0, "reset valid");
    chk({16'h0, precise_tag_out}, 48'h0, "reset tag");
  endtask : t_reset
  // Precise event: tag capture, one-cycle pulse, both wrong directions
  task t_precise;
    run(8'hc5, 8'h00, 1'b1, 1'b1, 1'b0, 32'hcafe_0001, 1'b0, 1'b0, 1, 1);
    chk({47'h0, precise_valid_out}, 48'h1, "precise pulse");
    chk({16'h0, precise_tag_out}, 48'hcafe_0001, "precise tag");
    @(posedge clk_in);
    #1;
    chk({47'h0, precise_valid_out}, 48'h0, "pulse length");
    run(8'hc5, 8'h00, 1'b1, 1'b0, 1'b1, 32'hbeef_0002, 1'b0, 1'b0, 3, 3);
    chk({16'h0, precise_tag_out}, 48'hbeef_0002, "latest tag");
    run(8'hc5, 8'h00, 1'b1, 1'b1, 1'b1, 32'h1234_0003, 1'b0, 1'b0, 2, 0);
    run(8'hc5, 8'h00, 1'b1, 1'b0, 1'b0, 32'h1234_0004, 1'b0, 1'b0, 2, 0);
    chk({16'h0, precise_tag_out}, 48'hbeef_0002, "tag held");
  endtask : t_precise
  // Duplicate branch event counts alike but raises no precise pulse
  task t_alt;
    run(8'hc4, 8'h0f, 1'b1, 1'b0, 1'b1, 32'h0000_0005, 1'b0, 1'b0, 3, 3);
    chk({47'h0, precise_valid_out}, 48'h0, "no pulse for c4h");
    run(8'hc4, 8'h0f, 1'b1, 1'b1, 1'b1, 32'h0000_0006, 1'b0, 1'b0, 2, 0);
    run(8'hc4, 8'h0c, 1'b1, 1'b0, 1'b1, 32'h0000_0007, 1'b0, 1'b0, 2, 0);
  endtask : t_alt
  task t_int;
    run(8'hc6, 8'h01, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 4, 4);
    run(8'hc6, 8'h01, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 1'b1, 3, 0);
    run(8'hc6, 8'h02, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 1'b1, 3, 3);
    run(8'hc6, 8'h02, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 3, 0);
    run(8'hc6, 8'h02, 1'b0, 1'b0, 1'b0, 32'h0, 1'b0, 1'b1, 2, 0);
  endtask : t_int
  // Every event condition active (retire with a mispredict, disabled, pending) under undefined selections
  task t_other;
    run(8'hc7, 8'h01, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b1, 3, 0);
    run(8'hc6, 8'h03, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b1, 3, 0);
    run(8'hc4, 8'h00, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b1, 3, 0);
    run(8'hc5, 8'h01, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 1'b1, 3, 0);
    chk({47'h0, precise_valid_out}, 48'h0, "no pulse for c5h other mask");
  endtask : t_other
  // Back-to-back branches with different tags: the record follows each one
  task t_tags;
    @(posedge clk_in);
    evt_sel_in <= 8'hc5;
    umask_in <= 8'h00;
    br_retire_in <= 1'b1;
    br_pred_taken_in <= 1'b0;
    br_taken_in <= 1'b1;
    br_tag_in <= 32'h0a0a_0010;
    @(posedge clk_in);
    br_tag_in <= 32'h0b0b_0011;
    #1;
    chk({16'h0, precise_tag_out}, 48'h0a0a_0010, "first tag");
    @(posedge clk_in);
    br_retire_in <= 1'b0;
    #1;
    chk({16'h0, precise_tag_out}, 48'h0b0b_0011, "second tag");
    chk({47'h0, precise_valid_out}, 48'h1, "second pulse");
  endtask : t_tags
  // Reset in mid-run clears everything, and counting resumes right after release
  task t_rst_mid;
    run(8'hc5, 8'h00, 1'b1, 1'b1, 1'b0, 32'h0f0f_0009, 1'b0, 1'b0, 2, 2);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    t_reset();
    run(8'hc6, 8'h01, 1'b0, 1'b0, 1'b0, 32'h0, 1'b1, 1'b0, 2, 2);
  endtask : t_rst_mid
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    t_reset();
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    t_precise();
    t_alt();
    t_int();
    t_other();
    t_tags();
    t_rst_mid();
    close_out();
  end
endmodule : bic_counter_tb
